// ==== core/exp_bus_defs.svh ====
// Constants for the expansion bus arbitration and signalling block.
// Assumes inclusion by bare name from files under core/.
// Contract
// RULE1 - Each host-port ready input has a selectable active-high or active-low polarity.
// RULE2 - Host-port chip selects 4..7 stall their access while their ready says not-ready.
// RULE3 - One ready input per chip select 4..7; never affects chip selects 0..3.
// RULE4 - Board keeps slave hold input high when idle and in sync/host-port cycles.
// RULE5 - Four parity bits, one per data byte, driven with the data.
// RULE6 - External master raises its request low and waits for its grant.
// RULE7 - External arbiter mode enables pull-ups on the three request inputs.
// RULE8 - Request answered by grant of same index; grants all high during reset.
// RULE9 - Shared input is fourth request as arbiter, external grant otherwise.
// RULE10 - Shared output is fourth grant as arbiter, own request otherwise; high in reset.
// RULE11 - Target select asserted means external master accesses us as a target.
// RULE12 - Asynchronous modes stall while slave hold input is low, resume when high.
// RULE13 - Drive target wait while selected until data ready; release after deselect.
// RULE14 - At most one grant; no new grant until owner drops its request.
// RULE15 - Parity polarity configurable, even by default, checked by receiver.
`ifndef EXP_BUS_DEFS_SVH
`define EXP_BUS_DEFS_SVH

`define EXP_NUM_CS        8
`define EXP_HP_CS_LO      4
`define EXP_NUM_MASTERS   4
`define EXP_DATA_W        32
`define EXP_PAR_W         4
`define EXP_GNT_RESET     3'h7
`define EXP_PAR_EVEN      1'h0

`endif

// ==== core/exp_bus_pkg.sv ====
// Types for the expansion bus arbitration block.
// Assumes no surroundings beyond the defs header.
package exp_bus_pkg;

  typedef enum logic [1:0] {
    ARB_IDLE  = 2'b00,
    ARB_GRANT = 2'b01,
    ARB_HOLD  = 2'b10
  } arb_state_t;

  typedef enum logic [1:0] {
    TGT_IDLE = 2'b00,
    TGT_WAIT = 2'b01,
    TGT_DONE = 2'b10
  } tgt_state_t;

  typedef enum logic [1:0] {
    CS_MODE_ASYNC = 2'b00,
    CS_MODE_SYNC  = 2'b01,
    CS_MODE_HPI   = 2'b10
  } cs_mode_t;

endpackage : exp_bus_pkg

// ==== core/exp_parity.sv ====
// Byte-lane parity generator and checker for the wide data bus.
// Assumes data inputs already synchronised to REF_CLK.
`timescale 1ns/1ps
`default_nettype none
`include "exp_bus_defs.svh"
module exp_parity #(
  parameter int DATA_W = `EXP_DATA_W,
  parameter int PAR_W  = `EXP_PAR_W
) (
  input  wire logic              odd_sel,
  input  wire logic [DATA_W-1:0] tx_data,
  output logic      [PAR_W-1:0]  tx_par,
  input  wire logic [DATA_W-1:0] rx_data,
  input  wire logic [PAR_W-1:0]  rx_par,
  output logic      [PAR_W-1:0]  rx_err
);

  // One parity bit for one byte lane
  function automatic logic lane_par(input logic [7:0] b, input logic odd);
    lane_par = (^b) ^ odd;
  endfunction : lane_par

  // Generate outgoing parity and compare incoming per lane
  always_comb begin
    for (int i = 0; i < PAR_W; i++) begin
      tx_par[i] = lane_par(tx_data[i*8 +: 8], odd_sel); // RULE5
      rx_err[i] = lane_par(rx_data[i*8 +: 8], odd_sel) ^ rx_par[i]; // RULE15
    end
  end

endmodule : exp_parity
`default_nettype wire

// ==== core/exp_bus_ctrl.sv ====
// Expansion bus arbiter, host-port ready, wait and target-select control.
// Assumes pins arrive asynchronously; pad logic resolves enables to wires.
`timescale 1ns/1ps
`default_nettype none
`include "exp_bus_defs.svh"
module exp_bus_ctrl #(
  parameter int NUM_CS = `EXP_NUM_CS,
  parameter int DATA_W = `EXP_DATA_W,
  parameter int PAR_W  = `EXP_PAR_W
) (
  input  wire logic                 REF_CLK,
  input  wire logic                 RST_N,
  // Configuration
  input  wire logic                 EXT_ARB_MODE,
  input  wire logic                 ODD_PARITY,
  input  wire logic [7:0]           HOST_PORT_MODE,
  input  wire logic [7:0]           ASYNC_MODE,
  input  wire logic [3:0]           READY_ACT_HIGH,
  // Arbitration pins
  input  wire logic [2:0]           MASTER_REQUEST_LINES_N,
  output logic                      REQUEST_PULLUP_EN,
  output logic      [2:0]           MASTER_GRANT_LINES_N,
  input  wire logic                 SHARED_REQUEST_OR_GRANT_IN_N,
  output logic                      SHARED_GRANT_OR_REQUEST_OUT_N,
  // Own bus need and ownership
  input  wire logic                 OWN_BUS_REQ,
  output logic                      OWN_BUS_GRANTED,
  // Outbound access stall
  input  wire logic [7:0]           CHIP_SELECT_LINES_N,
  input  wire logic [3:0]           HOST_PORT_READY_LINES,
  input  wire logic                 SLAVE_HOLD_INPUT_N,
  output logic                      ACCESS_STALL,
  // Target side
  input  wire logic                 TARGET_SELECT_INPUT_N,
  input  wire logic                 TARGET_DATA_READY,
  output logic                      TARGET_ACCESS,
  output logic                      TARGET_WAIT_OUTPUT_N_O,
  output logic                      TARGET_WAIT_OUTPUT_OE,
  // Data and parity
  input  wire logic [DATA_W-1:0]    WIDE_DATA_BUS_I,
  input  wire logic [PAR_W-1:0]     BYTE_PARITY_BITS_I,
  input  wire logic [DATA_W-1:0]    TX_DATA,
  input  wire logic                 TX_DRIVE,
  output logic      [DATA_W-1:0]    WIDE_DATA_BUS_O,
  output logic      [PAR_W-1:0]     BYTE_PARITY_BITS_O,
  output logic                      DATA_OE,
  output logic      [PAR_W-1:0]     PARITY_ERROR
);

  // Two-stage synchronisers for all pin inputs
  logic [2:0]        req_m_q, req_s_q;
  logic              rg_m_q, rg_s_q;
  logic [7:0]        cs_m_q, cs_s_q;
  logic [3:0]        rdy_m_q, rdy_s_q;
  logic              hold_m_q, hold_s_q;
  logic              tsel_m_q, tsel_s_q;
  logic [DATA_W-1:0] dat_m_q, dat_s_q;
  logic [PAR_W-1:0]  par_m_q, par_s_q;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      req_m_q  <= 3'h7;
      req_s_q  <= 3'h7;
      rg_m_q   <= 1'h1;
      rg_s_q   <= 1'h1;
      cs_m_q   <= 8'hff;
      cs_s_q   <= 8'hff;
      rdy_m_q  <= 4'h0;
      rdy_s_q  <= 4'h0;
      hold_m_q <= 1'h1;
      hold_s_q <= 1'h1;
      tsel_m_q <= 1'h1;
      tsel_s_q <= 1'h1;
      dat_m_q  <= '0;
      dat_s_q  <= '0;
      par_m_q  <= '0;
      par_s_q  <= '0;
    end else begin
      req_m_q  <= MASTER_REQUEST_LINES_N;
      req_s_q  <= req_m_q;
      rg_m_q   <= SHARED_REQUEST_OR_GRANT_IN_N;
      rg_s_q   <= rg_m_q;
      cs_m_q   <= CHIP_SELECT_LINES_N;
      cs_s_q   <= cs_m_q;
      rdy_m_q  <= HOST_PORT_READY_LINES;
      rdy_s_q  <= rdy_m_q;
      hold_m_q <= SLAVE_HOLD_INPUT_N;
      hold_s_q <= hold_m_q;
      tsel_m_q <= TARGET_SELECT_INPUT_N;
      tsel_s_q <= tsel_m_q;
      dat_m_q  <= WIDE_DATA_BUS_I;
      dat_s_q  <= dat_m_q;
      par_m_q  <= BYTE_PARITY_BITS_I;
      par_s_q  <= par_m_q;
    end
  end

  // Pull-ups held on the request pins in external arbiter mode
  assign REQUEST_PULLUP_EN = EXT_ARB_MODE; // RULE7

  // Requests from four masters; fourth on the shared input when arbitrating
  logic [3:0] req_vec;
  assign req_vec = EXT_ARB_MODE ? 4'h0 : {~rg_s_q, ~req_s_q}; // RULE9

  // Arbiter: one owner, held until it drops its request
  exp_bus_pkg::arb_state_t arb_q;
  logic [1:0]              owner_q;
  logic [1:0]              last_q;

  // Round-robin pick after the last owner
  function automatic logic [1:0] pick(input logic [3:0] r, input logic [1:0] last);
    logic [1:0] idx;
    pick = last;
    for (int i = 4; i >= 1; i--) begin
      idx = 2'(last + 2'(i));
      if (r[idx]) pick = idx;
    end
  endfunction : pick

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      arb_q   <= exp_bus_pkg::ARB_IDLE;
      owner_q <= 2'h0;
      last_q  <= 2'h3;
    end else begin
      case (arb_q)
        exp_bus_pkg::ARB_IDLE: begin
          if (req_vec != 4'h0) begin
            owner_q <= pick(req_vec, last_q);
            arb_q   <= exp_bus_pkg::ARB_GRANT; // RULE8
          end
        end
        exp_bus_pkg::ARB_GRANT: begin
          if (!req_vec[owner_q]) begin
            last_q <= owner_q;
            arb_q  <= exp_bus_pkg::ARB_HOLD; // RULE14
          end
        end
        exp_bus_pkg::ARB_HOLD: arb_q <= exp_bus_pkg::ARB_IDLE; // RULE14
        default: arb_q <= exp_bus_pkg::ARB_IDLE;
      endcase
    end
  end

  // Grant outputs registered; all high in reset
  logic [3:0] gnt_q;
  logic       own_req_q;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      gnt_q     <= 4'h0;
      own_req_q <= 1'h0;
    end else begin
      gnt_q     <= (arb_q == exp_bus_pkg::ARB_GRANT && req_vec[owner_q] && !EXT_ARB_MODE)
                   ? 4'(1 << owner_q) : 4'h0; // RULE14
      own_req_q <= EXT_ARB_MODE & OWN_BUS_REQ;
    end
  end

  assign MASTER_GRANT_LINES_N = RST_N ? ~gnt_q[2:0] : `EXP_GNT_RESET; // RULE8
  assign SHARED_GRANT_OR_REQUEST_OUT_N = !RST_N ? 1'h1 :
                                         EXT_ARB_MODE ? ~own_req_q : ~gnt_q[3]; // RULE10
  assign OWN_BUS_GRANTED = EXT_ARB_MODE ? (own_req_q & ~rg_s_q) // RULE9
                                        : (gnt_q == 4'h0 && req_vec == 4'h0);

  // Host-port ready decode with polarity per line
  logic [3:0] hp_ready_lvl;
  assign hp_ready_lvl = READY_ACT_HIGH & rdy_s_q | ~READY_ACT_HIGH & ~rdy_s_q; // RULE1

  // Stall: ready gates only chip selects 4..7 in host-port mode
  logic [7:0] cs_act;
  logic       hp_stall, async_stall;
  assign cs_act      = ~cs_s_q;
  assign hp_stall    = |(cs_act[7:4] & HOST_PORT_MODE[7:4] & ~hp_ready_lvl); // RULE2 RULE3
  assign async_stall = |(cs_act & ASYNC_MODE & ~HOST_PORT_MODE) & ~hold_s_q; // RULE12

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) ACCESS_STALL <= 1'h0;
    else        ACCESS_STALL <= hp_stall | async_stall;
  end

  // Target access: wait driven while selected until data ready
  exp_bus_pkg::tgt_state_t tgt_q;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tgt_q <= exp_bus_pkg::TGT_IDLE;
    end else begin
      case (tgt_q)
        exp_bus_pkg::TGT_IDLE: if (!tsel_s_q) tgt_q <= exp_bus_pkg::TGT_WAIT; // RULE11
        exp_bus_pkg::TGT_WAIT: begin
          if (tsel_s_q) tgt_q <= exp_bus_pkg::TGT_IDLE;
          else if (TARGET_DATA_READY) tgt_q <= exp_bus_pkg::TGT_DONE;
        end
        exp_bus_pkg::TGT_DONE: if (tsel_s_q) tgt_q <= exp_bus_pkg::TGT_IDLE; // RULE13
        default: tgt_q <= exp_bus_pkg::TGT_IDLE;
      endcase
    end
  end

  assign TARGET_ACCESS          = (tgt_q != exp_bus_pkg::TGT_IDLE); // RULE11
  assign TARGET_WAIT_OUTPUT_OE  = TARGET_ACCESS; // RULE13
  assign TARGET_WAIT_OUTPUT_N_O = (tgt_q != exp_bus_pkg::TGT_WAIT); // RULE13

  // Outgoing data and parity registered together
  logic [PAR_W-1:0] tx_par, rx_err;
  exp_parity #(.DATA_W(DATA_W), .PAR_W(PAR_W)) u_par (
    .odd_sel (ODD_PARITY),
    .tx_data (TX_DATA),
    .tx_par  (tx_par),
    .rx_data (dat_s_q),
    .rx_par  (par_s_q),
    .rx_err  (rx_err)
  );

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      WIDE_DATA_BUS_O    <= '0;
      BYTE_PARITY_BITS_O <= '0;
      DATA_OE            <= 1'h0;
      PARITY_ERROR       <= '0;
    end else begin
      WIDE_DATA_BUS_O    <= TX_DATA;
      BYTE_PARITY_BITS_O <= tx_par; // RULE5
      DATA_OE            <= TX_DRIVE;
      PARITY_ERROR       <= TX_DRIVE ? 4'h0 : rx_err; // RULE15
    end
  end

endmodule : exp_bus_ctrl
`default_nettype wire

// ==== bench/ext_masters.sv ====
// Partner model of external masters 1 to 3 on the arbitration pins.
// Assumes active-low grants from the arbiter; the bench sets which master wants the bus.
`timescale 1ns/1ps
`default_nettype none
module ext_masters (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] want,
  input  wire logic [2:0] gnt_n,
  output logic      [2:0] req_n
);
  // A request is held low until its grant has been seen and the master is done
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_n <= 3'h7;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (want[i]) begin
          req_n[i] <= 1'b0;
        end else if (!gnt_n[i]) begin
          req_n[i] <= 1'b1;
        end
      end
    end
  end
endmodule : ext_masters
`default_nettype wire

// ==== bench/exp_bus_checker.sv ====
// Concurrent checks on the ports of the expansion bus control block.
// Assumes configuration inputs change only between transfers.
`timescale 1ns/1ps
`default_nettype none
module exp_bus_checker (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        EXT_ARB_MODE,
  input wire logic        ODD_PARITY,
  input wire logic        OWN_BUS_REQ,
  input wire logic        OWN_BUS_GRANTED,
  input wire logic        REQUEST_PULLUP_EN,
  input wire logic        SHARED_REQUEST_OR_GRANT_IN_N,
  input wire logic        SHARED_GRANT_OR_REQUEST_OUT_N,
  input wire logic        SLAVE_HOLD_INPUT_N,
  input wire logic        ACCESS_STALL,
  input wire logic        TARGET_SELECT_INPUT_N,
  input wire logic        TARGET_DATA_READY,
  input wire logic        TARGET_WAIT_OUTPUT_N_O,
  input wire logic        TARGET_WAIT_OUTPUT_OE,
  input wire logic        DATA_OE,
  input wire logic [2:0]  MASTER_REQUEST_LINES_N,
  input wire logic [2:0]  MASTER_GRANT_LINES_N,
  input wire logic [7:0]  ASYNC_MODE,
  input wire logic [7:0]  CHIP_SELECT_LINES_N,
  input wire logic [31:0] WIDE_DATA_BUS_O,
  input wire logic [3:0]  BYTE_PARITY_BITS_O
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Arbitration pins
  property p_rst; $rose(RST_N) |-> MASTER_GRANT_LINES_N == 3'h7 && SHARED_GRANT_OR_REQUEST_OUT_N; endproperty
  a_rst: assert property (p_rst) else $error("grants busy at reset release");
  property p_one; $onehot0({~MASTER_GRANT_LINES_N, !EXT_ARB_MODE && !SHARED_GRANT_OR_REQUEST_OUT_N}); endproperty
  a_one: assert property (p_one) else $error("two grants at once");
  property p_gnt; $fell(MASTER_GRANT_LINES_N[1]) |-> $past(!MASTER_REQUEST_LINES_N[1], 2); endproperty
  a_gnt: assert property (p_gnt) else $error("grant without request");
  property p_rel; MASTER_REQUEST_LINES_N[1] [*4] |-> MASTER_GRANT_LINES_N[1]; endproperty
  a_rel: assert property (p_rel) else $error("grant kept after release");
  property p_pull; REQUEST_PULLUP_EN == EXT_ARB_MODE; endproperty
  a_pull: assert property (p_pull) else $error("pull-up enable wrong");
  property p_ext; (EXT_ARB_MODE && OWN_BUS_REQ) [*4] |-> !SHARED_GRANT_OR_REQUEST_OUT_N; endproperty
  a_ext: assert property (p_ext) else $error("own request missing");
  property p_xg; (EXT_ARB_MODE && OWN_BUS_REQ && !SHARED_REQUEST_OR_GRANT_IN_N) [*4] |-> OWN_BUS_GRANTED; endproperty
  a_xg: assert property (p_xg) else $error("external grant ignored");
  // Access stall
  property p_hold; (ASYNC_MODE[0] && CHIP_SELECT_LINES_N == 8'hfe && !SLAVE_HOLD_INPUT_N) [*4] |-> ACCESS_STALL;
  endproperty
  a_hold: assert property (p_hold) else $error("hold input ignored");
  property p_cs0; (!ASYNC_MODE[0] && CHIP_SELECT_LINES_N == 8'hfe) [*4] |-> !ACCESS_STALL; endproperty
  a_cs0: assert property (p_cs0) else $error("low chip select stalled");
  // Target wait and parity
  property p_tw; (!TARGET_SELECT_INPUT_N && !TARGET_DATA_READY) [*4] |-> TARGET_WAIT_OUTPUT_OE && !TARGET_WAIT_OUTPUT_N_O;
  endproperty
  a_tw: assert property (p_tw) else $error("target not held off");
  property p_toff; TARGET_SELECT_INPUT_N [*4] |-> !TARGET_WAIT_OUTPUT_OE; endproperty
  a_toff: assert property (p_toff) else $error("wait driven while deselected");
  property p_par; DATA_OE && $stable(ODD_PARITY) |-> BYTE_PARITY_BITS_O[0] == (^WIDE_DATA_BUS_O[7:0] ^ ODD_PARITY);
  endproperty
  a_par: assert property (p_par) else $error("lane parity wrong");
  c_gnt: cover property ($fell(MASTER_GRANT_LINES_N[1]));
  c_stall: cover property ($rose(ACCESS_STALL));
  c_tw: cover property ($rose(TARGET_WAIT_OUTPUT_OE));
endmodule : exp_bus_checker
bind exp_bus_ctrl exp_bus_checker exp_bus_checker_inst (.REF_CLK, .RST_N, .EXT_ARB_MODE, .ODD_PARITY, .OWN_BUS_REQ,
  .OWN_BUS_GRANTED, .REQUEST_PULLUP_EN, .SHARED_REQUEST_OR_GRANT_IN_N, .SHARED_GRANT_OR_REQUEST_OUT_N,
  .SLAVE_HOLD_INPUT_N, .ACCESS_STALL, .TARGET_SELECT_INPUT_N, .TARGET_DATA_READY, .TARGET_WAIT_OUTPUT_N_O,
  .TARGET_WAIT_OUTPUT_OE, .DATA_OE, .MASTER_REQUEST_LINES_N, .MASTER_GRANT_LINES_N, .ASYNC_MODE,
  .CHIP_SELECT_LINES_N, .WIDE_DATA_BUS_O, .BYTE_PARITY_BITS_O);
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the expansion bus control block.
// Assumes the checker binds itself and the partner plays masters 1 to 3.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        REF_CLK, RST_N, EXT_ARB_MODE, ODD_PARITY, SHARED_REQUEST_OR_GRANT_IN_N, OWN_BUS_REQ, TX_DRIVE;
  logic        SLAVE_HOLD_INPUT_N, TARGET_SELECT_INPUT_N, TARGET_DATA_READY, REQUEST_PULLUP_EN, OWN_BUS_GRANTED;
  logic        SHARED_GRANT_OR_REQUEST_OUT_N, ACCESS_STALL, TARGET_ACCESS, TARGET_WAIT_OUTPUT_N_O;
  logic        TARGET_WAIT_OUTPUT_OE, DATA_OE;
  logic [7:0]  HOST_PORT_MODE, ASYNC_MODE, CHIP_SELECT_LINES_N;
  logic [3:0]  READY_ACT_HIGH, HOST_PORT_READY_LINES, BYTE_PARITY_BITS_I, BYTE_PARITY_BITS_O, PARITY_ERROR;
  logic [2:0]  MASTER_REQUEST_LINES_N, MASTER_GRANT_LINES_N, want;
  logic [31:0] WIDE_DATA_BUS_I, TX_DATA, WIDE_DATA_BUS_O, d;
  int          failures, cmp_count;
  wire  [3:0]  gnts = {~SHARED_GRANT_OR_REQUEST_OUT_N, ~MASTER_GRANT_LINES_N};
  exp_bus_ctrl exp_bus_ctrl_inst (.REF_CLK, .RST_N, .EXT_ARB_MODE, .ODD_PARITY, .HOST_PORT_MODE, .ASYNC_MODE,
    .READY_ACT_HIGH, .MASTER_REQUEST_LINES_N, .REQUEST_PULLUP_EN, .MASTER_GRANT_LINES_N,
    .SHARED_REQUEST_OR_GRANT_IN_N, .SHARED_GRANT_OR_REQUEST_OUT_N, .OWN_BUS_REQ, .OWN_BUS_GRANTED,
    .CHIP_SELECT_LINES_N, .HOST_PORT_READY_LINES, .SLAVE_HOLD_INPUT_N, .ACCESS_STALL, .TARGET_SELECT_INPUT_N,
    .TARGET_DATA_READY, .TARGET_ACCESS, .TARGET_WAIT_OUTPUT_N_O, .TARGET_WAIT_OUTPUT_OE, .WIDE_DATA_BUS_I,
    .BYTE_PARITY_BITS_I, .TX_DATA, .TX_DRIVE, .WIDE_DATA_BUS_O, .BYTE_PARITY_BITS_O, .DATA_OE, .PARITY_ERROR);
  ext_masters ext_masters_inst (.clk(REF_CLK), .rst_n(RST_N), .want(want), .gnt_n(MASTER_GRANT_LINES_N),
    .req_n(MASTER_REQUEST_LINES_N));
  // Clock and watchdog
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
  task automatic w(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : w
  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Waits a bounded time for a grant pattern, bit 3 being the fourth master
  task automatic wg(input logic [3:0] exp);
    for (int k = 0; k < 20 && gnts !== exp; k++) w(1);
    chk("grants", exp, gnts);
  endtask : wg
  function automatic logic [3:0] par(input logic [31:0] v, input logic o);
    for (int i = 0; i < 4; i++) par[i] = ^v[8*i +: 8] ^ o;
  endfunction : par
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    {RST_N, EXT_ARB_MODE, ODD_PARITY, OWN_BUS_REQ, TX_DRIVE, TARGET_DATA_READY, want} = '0;
    {SHARED_REQUEST_OR_GRANT_IN_N, SLAVE_HOLD_INPUT_N, TARGET_SELECT_INPUT_N} = 3'h7;
    {HOST_PORT_MODE, ASYNC_MODE, READY_ACT_HIGH, HOST_PORT_READY_LINES, BYTE_PARITY_BITS_I} = '0;
    {WIDE_DATA_BUS_I, TX_DATA} = '0;
    CHIP_SELECT_LINES_N = 8'hff;
    failures = 0;
    cmp_count = 0;
    w(6);
    chk("reset grants", 4'h0, gnts);
    RST_N <= 1'b1;
    w(4);
    want <= 3'h2;
    wg(4'h2);
    want <= 3'h3;
    w(6);
    chk("held grant", 4'h2, gnts);
    want <= 3'h1;
    wg(4'h1);
    want <= 3'h0;
    SHARED_REQUEST_OR_GRANT_IN_N <= 1'b0;
    wg(4'h8);
    SHARED_REQUEST_OR_GRANT_IN_N <= 1'b1;
    wg(4'h0);
    chk("arbiter owns bus", 1'b1, OWN_BUS_GRANTED);
    {EXT_ARB_MODE, OWN_BUS_REQ} <= 2'h3;
    w(6);
    chk("pull-up", 1'b1, REQUEST_PULLUP_EN);
    chk("own request", 4'h8, gnts);
    chk("not granted", 1'b0, OWN_BUS_GRANTED);
    SHARED_REQUEST_OR_GRANT_IN_N <= 1'b0;
    w(6);
    chk("granted", 1'b1, OWN_BUS_GRANTED);
    {EXT_ARB_MODE, OWN_BUS_REQ, SHARED_REQUEST_OR_GRANT_IN_N} <= 3'h1;
    HOST_PORT_MODE <= 8'hf0;
    CHIP_SELECT_LINES_N <= 8'hef;
    for (int p = 0; p < 2; p++) begin
      READY_ACT_HIGH <= {4{p[0]}};
      HOST_PORT_READY_LINES <= {4{~p[0]}};
      w(6);
      chk("not ready", 1'b1, ACCESS_STALL);
      HOST_PORT_READY_LINES <= {4{p[0]}};
      w(6);
      chk("ready", 1'b0, ACCESS_STALL);
    end
    // Chip select 5 listens only to its own ready line
    CHIP_SELECT_LINES_N <= 8'hdf;
    HOST_PORT_READY_LINES <= 4'h2;
    w(6);
    chk("own ready only", 1'b0, ACCESS_STALL);
    HOST_PORT_READY_LINES <= 4'hd;
    w(6);
    chk("own ready low", 1'b1, ACCESS_STALL);
    HOST_PORT_READY_LINES <= 4'h0;
    CHIP_SELECT_LINES_N <= 8'hfe;
    w(6);
    chk("cs0 ready", 1'b0, ACCESS_STALL);
    ASYNC_MODE <= 8'h01;
    SLAVE_HOLD_INPUT_N <= 1'b0;
    w(6);
    chk("hold", 1'b1, ACCESS_STALL);
    SLAVE_HOLD_INPUT_N <= 1'b1;
    w(6);
    chk("resume", 1'b0, ACCESS_STALL);
    CHIP_SELECT_LINES_N <= 8'hff;
    TARGET_SELECT_INPUT_N <= 1'b0;
    w(6);
    chk("target hold", 3'h6, {TARGET_ACCESS, TARGET_WAIT_OUTPUT_OE, TARGET_WAIT_OUTPUT_N_O});
    TARGET_DATA_READY <= 1'b1;
    w(3);
    chk("target go", 2'h3, {TARGET_WAIT_OUTPUT_OE, TARGET_WAIT_OUTPUT_N_O});
    {TARGET_SELECT_INPUT_N, TARGET_DATA_READY} <= 2'h2;
    w(6);
    chk("target off", 2'h0, {TARGET_ACCESS, TARGET_WAIT_OUTPUT_OE});
    for (int i = 0; i < 4; i++) begin
      d = 32'h01a3_ff70 << (4 * i);
      ODD_PARITY <= i[1];
      TX_DATA <= d;
      TX_DRIVE <= 1'b1;
      w(3);
      chk("tx data", {1'b1, d}, {DATA_OE, WIDE_DATA_BUS_O});
      chk("tx parity", par(d, i[1]), BYTE_PARITY_BITS_O);
      TX_DRIVE <= 1'b0;
      WIDE_DATA_BUS_I <= d;
      BYTE_PARITY_BITS_I <= par(d, i[1]) ^ 4'h5;
      w(6);
      chk("rx error", 4'h5, PARITY_ERROR);
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
